// [rtl/dcs_sequencer.sv]
// Four-channel DMA sequencer with APB register slave
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - No flyby with synchronous DRAM
// - 16-bit wide-to-narrow: one read, two writes
// - Narrow-to-wide: two reads, one write, endian order
// - Byte from wide bus: upper lanes released
// - Byte to wide bus: upper lanes released
// - Little and big endian regions interoperate
// - Two-cycle bus cycle chosen by target
// - Flyby uses dedicated flyby cycle
// - Fixed priority, channel 0 highest
// - Arbitrate only idle; block never switches
// - Single-step regrants higher priority in idle
// - Address and count are master/slave pairs
// - Idle writes update both stages
// - Busy writes hit master; reads slave
// - Transfer ends at count or init
// - Pre-start write overwrites both stages
// - External request level-sampled each clock
// - External request starts enabled idle channel
// - Software trigger starts enabled channel
// - Peripheral interrupt starts enabled channel
module dcs_sequencer
   import dcs_pkg::*;
#(
   parameter int NCH = 4,
   parameter int NPER = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Start sources
   input wire logic [NCH-1:0] ext_transfer_request,
   input wire logic [NPER-1:0] periph_irq,
   // External bus
   input wire logic bus_ready,
   input wire logic [15:0] bus_rdata_in,
   output logic [31:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output logic [1:0] bus_lane_en,
   output logic [2:0] bus_cycle,
   output logic [15:0] bus_wdata_out,
   output logic [15:0] bus_data_oe_n,
   output logic [NCH-1:0] transfer_acknowledge,
   output logic [NCH-1:0] terminal_count_pulse
);
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [31:0] src_m_q [NCH];
   logic [31:0] src_s_q [NCH];
   logic [31:0] dst_m_q [NCH];
   logic [31:0] dst_s_q [NCH];
   logic [15:0] cnt_m_q [NCH];
   logic [15:0] cnt_s_q [NCH];
   logic [15:0] mode_q [NCH];
   logic [7:0] trig_q [NCH];
   logic [NCH-1:0] en_q, tc_q, stg_q, busy_q, reload_q;
   logic [31:0] bct_q;
   dcs_state_t st_q;
   logic [1:0] ch_q;
   logic rd_phase_q;
   logic [15:0] hold_q;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire acc = psel && penable;
   // Registers change only at the edge that completes the transfer
   wire done = acc && pready;
   wire wr_acc = done && pwrite;
   wire [1:0] a_ch = paddr[6:5];
   wire [4:0] a_off = paddr[4:0];
   wire in_ch = (paddr < 12'h080);
   wire a_src = in_ch && (a_off == DCS_OFF_SRC);
   wire a_dst = in_ch && (a_off == DCS_OFF_DST);
   wire a_cnt = in_ch && (a_off == DCS_OFF_CNT);
   wire a_ctl = in_ch && (a_off == DCS_OFF_CTRL);
   wire a_trg = in_ch && (a_off == DCS_OFF_TRIG);
   wire a_mod = in_ch && (a_off == DCS_OFF_MODE);
   wire a_bct = (paddr == DCS_OFF_BCT);
   wire a_sta = (paddr == DCS_OFF_STAT);
   wire mapped = a_src | a_dst | a_cnt | a_ctl | a_trg | a_mod | a_bct | a_sta;

   // Legality of a channel's pairing; flyby only external memory with external I/O
   function automatic logic legal(input logic [15:0] m);
      logic [2:0] s;
      logic [2:0] d;
      s = m[DCS_MODE_SK +: 3];
      d = m[DCS_MODE_DK +: 3];
      if (m[DCS_MODE_FLY]) begin
         // SDRAM on either side is refused for flyby
         legal = ((s == DCS_T_EXTMEM && d == DCS_T_EXTIO) ||
                  (s == DCS_T_EXTIO && d == DCS_T_EXTMEM));
      end else begin
         legal = (d != DCS_T_IROM) && !(s == DCS_T_IRAM && d == DCS_T_IRAM);
      end
   endfunction

   // Bus cycle for one side of a two-cycle transfer
   function automatic logic [2:0] cyc_of(input logic [2:0] t);
      unique case (t)
         DCS_T_EXTIO: cyc_of = DCS_CYC_SRAM;
         DCS_T_EXTMEM, DCS_T_SDRAM: cyc_of = DCS_CYC_BCT;
         default: cyc_of = DCS_CYC_NONE;
      endcase
   endfunction

   // ----------------------------------------
   // Start requests and fixed priority
   // ----------------------------------------
   logic [NCH-1:0] req;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         req[i] = en_q[i] && !tc_q[i] && legal(mode_q[i]) &&
            (mode_q[i][DCS_MODE_SW] ? stg_q[i] :
             trig_q[i][DCS_TRIG_PER] ? periph_irq[trig_q[i][2:0]] :
             ext_transfer_request[i]);
      end
   end
   // Lowest index wins
   wire [1:0] win = req[0] ? 2'd0 : req[1] ? 2'd1 : req[2] ? 2'd2 : 2'd3;

   // Current channel configuration
   wire [15:0] cm = mode_q[ch_q];
   wire cfly = cm[DCS_MODE_FLY];
   wire chalf = cm[DCS_MODE_HALF];
   wire s8 = !cm[DCS_MODE_SW16];
   wire d8 = !cm[DCS_MODE_DW];
   wire sbig = cm[DCS_MODE_SBE];
   wire dbig = cm[DCS_MODE_SBE+2];
   wire [1:0] xm = cm[DCS_MODE_XFM +: 2];
   // Number of read beats and write beats, 1 or 2
   wire two_rd = chalf && s8 && !cfly;
   wire two_wr = chalf && d8 && !cfly;
   wire last = (cnt_s_q[ch_q] == 16'h0001);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= DCS_IDLE;
         ch_q <= 2'd0;
         rd_phase_q <= 1'b0;
         hold_q <= 16'h0000;
      end else begin
         unique case (st_q)
            DCS_IDLE: begin
               // Arbitration only happens here; step mode re-enters here each beat
               if (|req) begin
                  st_q <= DCS_START;
                  ch_q <= win;
               end
            end
            DCS_START: begin
               st_q <= cfly ? DCS_WR : DCS_RD;
               rd_phase_q <= 1'b0;
            end
            DCS_RD: if (bus_ready) begin
               // Gather bytes in endian order of the source region
               if (two_rd) begin
                  if (rd_phase_q ^ sbig) hold_q[15:8] <= bus_rdata_in[7:0];
                  else hold_q[7:0] <= bus_rdata_in[7:0];
               end else begin
                  hold_q <= s8 ? {8'h00, bus_rdata_in[7:0]} : bus_rdata_in;
               end
               if (two_rd && !rd_phase_q) rd_phase_q <= 1'b1;
               else begin
                  rd_phase_q <= 1'b0;
                  st_q <= DCS_GAP;
               end
            end
            DCS_GAP: st_q <= DCS_WR; // One idle clock between read and write
            DCS_WR: if (bus_ready) begin
               if (two_wr && !rd_phase_q) rd_phase_q <= 1'b1;
               else begin
                  rd_phase_q <= 1'b0;
                  // Block mode keeps the channel until terminal count or until its enable is cleared
                  st_q <= (xm == DCS_XM_BLOCK && !last && en_q[ch_q]) ? DCS_START : DCS_END;
               end
            end
            DCS_END: st_q <= DCS_IDLE;
            default: st_q <= DCS_IDLE;
         endcase
      end
   end

   wire beat_done = (st_q == DCS_WR) && bus_ready && !(two_wr && !rd_phase_q);
   wire rd_half = rd_phase_q ^ sbig;
   wire wr_half = rd_phase_q ^ dbig;

   // ----------------------------------------
   // External bus outputs
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_addr <= 32'h0;
         bus_rd <= 1'b0;
         bus_wr <= 1'b0;
         bus_lane_en <= 2'b00;
         bus_cycle <= DCS_CYC_NONE;
         bus_wdata_out <= 16'h0;
         bus_data_oe_n <= 16'hffff;
         transfer_acknowledge <= '0;
         terminal_count_pulse <= '0;
      end else begin
         bus_rd <= (st_q == DCS_RD) && !cfly;
         bus_wr <= (st_q == DCS_WR);
         bus_addr <= (st_q == DCS_RD || cfly) ? src_s_q[ch_q] + 32'(two_rd & rd_phase_q)
                     : dst_s_q[ch_q] + 32'(two_wr & rd_phase_q);
         if (cfly) bus_cycle <= DCS_CYC_FLY;
         else if (st_q == DCS_RD) bus_cycle <= cyc_of(cm[DCS_MODE_SK +: 3]);
         else if (st_q == DCS_WR) bus_cycle <= cyc_of(cm[DCS_MODE_DK +: 3]);
         else bus_cycle <= DCS_CYC_NONE;
         // Byte beats release the upper lanes
         bus_lane_en <= (st_q == DCS_RD) ? ((s8 || !chalf) ? 2'b01 : 2'b11)
                        : ((d8 || !chalf) ? 2'b01 : 2'b11);
         if (st_q == DCS_WR && !cfly) begin
            bus_data_oe_n <= (d8 || !chalf) ? 16'hff00 : 16'h0000;
            if (two_wr) bus_wdata_out <= {8'h00, wr_half ? hold_q[15:8] : hold_q[7:0]};
            else if (chalf && dbig) bus_wdata_out <= {hold_q[7:0], hold_q[15:8]};
            else bus_wdata_out <= hold_q;
         end else begin
            bus_data_oe_n <= 16'hffff;
         end
         for (int i = 0; i < NCH; i++) begin
            transfer_acknowledge[i] <= (st_q != DCS_IDLE) && (ch_q == 2'(i));
            terminal_count_pulse[i] <= beat_done && last && (ch_q == 2'(i));
         end
      end
   end

   // ----------------------------------------
   // Channel registers, two-stage address and count
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            src_m_q[i] <= 32'h0;
            src_s_q[i] <= 32'h0;
            dst_m_q[i] <= 32'h0;
            dst_s_q[i] <= 32'h0;
            cnt_m_q[i] <= 16'h0;
            cnt_s_q[i] <= 16'h0;
            mode_q[i] <= 16'h0;
            trig_q[i] <= 8'h0;
         end
         en_q <= '0;
         tc_q <= '0;
         stg_q <= '0;
         busy_q <= '0;
         bct_q <= 32'h0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            logic hit, ini;
            hit = wr_acc && (a_ch == 2'(i));
            ini = hit && a_ctl && pwdata[DCS_CTRL_INIT];
            // Busy from first accepted request until its end
            if (st_q == DCS_START && ch_q == 2'(i)) busy_q[i] <= 1'b1;
            if (beat_done && ch_q == 2'(i)) begin
               src_s_q[i] <= src_s_q[i] + (chalf ? 32'h2 : 32'h1);
               dst_s_q[i] <= dst_s_q[i] + (chalf ? 32'h2 : 32'h1);
               cnt_s_q[i] <= cnt_s_q[i] - 16'h0001;
               stg_q[i] <= 1'b0;
            end
            // Slave stage follows writes only while idle
            if (hit && a_src) begin
               src_m_q[i] <= pwdata;
               if (!busy_q[i]) src_s_q[i] <= pwdata;
            end
            if (hit && a_dst) begin
               dst_m_q[i] <= pwdata;
               if (!busy_q[i]) dst_s_q[i] <= pwdata;
            end
            if (hit && a_cnt) begin
               cnt_m_q[i] <= pwdata[15:0];
               if (!busy_q[i]) cnt_s_q[i] <= pwdata[15:0];
            end
            if (hit && a_mod) mode_q[i] <= pwdata[15:0];
            if (hit && a_trg) trig_q[i] <= pwdata[7:0];
            if (hit && a_ctl) begin
               en_q[i] <= pwdata[DCS_CTRL_EN];
               if (pwdata[DCS_CTRL_STG]) stg_q[i] <= 1'b1;
            end
            // Software clears terminal count by a read; the set wins
            if (done && !pwrite && a_ctl && a_ch == 2'(i)) tc_q[i] <= 1'b0;
            // End of transfer reloads slave from master
            if ((beat_done && last && ch_q == 2'(i)) || ini) begin
               src_s_q[i] <= src_m_q[i];
               dst_s_q[i] <= dst_m_q[i];
               cnt_s_q[i] <= cnt_m_q[i];
               busy_q[i] <= 1'b0;
               // A software trigger written in the same cycle survives
               if (!(hit && a_ctl && pwdata[DCS_CTRL_STG])) stg_q[i] <= 1'b0;
               if (ini) en_q[i] <= 1'b0;
               else tc_q[i] <= 1'b1;
            end
         end
         if (wr_acc && a_bct) bct_q <= pwdata;
      end
   end

   // ----------------------------------------
   // APB read mux, access phase with one wait state
   // ----------------------------------------
   wire [31:0] ctl_rd = {28'h0, 1'b0, stg_q[a_ch], tc_q[a_ch], en_q[a_ch]};
   wire [31:0] rd_mux = a_src ? src_s_q[a_ch] : a_dst ? dst_s_q[a_ch] :
                        a_cnt ? {16'h0, cnt_s_q[a_ch]} : a_ctl ? ctl_rd :
                        a_trg ? {24'h0, trig_q[a_ch]} : a_mod ? {16'h0, mode_q[a_ch]} :
                        a_bct ? bct_q : a_sta ? {26'h0, st_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Ready is raised one cycle into access so read data is registered
         pready <= acc && !pready;
         pslverr <= acc && !pready && !mapped;
         prdata <= (psel && !pwrite) ? rd_mux : 32'h0;
      end
   end
endmodule // dcs_sequencer

// [rtl/dcs_pkg.sv]
// Package: register map, field positions and encodings for the DMA channel sequencer
package dcs_pkg;
   // ----------------------------------------
   // Register map (one channel block each 0x20)
   // ----------------------------------------
   localparam logic [11:0] DCS_CH_STRIDE = 12'h020;
   localparam logic [4:0] DCS_OFF_SRC = 5'h00;
   localparam logic [4:0] DCS_OFF_DST = 5'h04;
   localparam logic [4:0] DCS_OFF_CNT = 5'h08;
   localparam logic [4:0] DCS_OFF_CTRL = 5'h0c;
   localparam logic [4:0] DCS_OFF_TRIG = 5'h10;
   localparam logic [4:0] DCS_OFF_MODE = 5'h14;
   localparam logic [11:0] DCS_OFF_BCT = 12'h080;
   localparam logic [11:0] DCS_OFF_STAT = 12'h084;
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int DCS_CTRL_EN = 0;
   localparam int DCS_CTRL_TC = 1;
   localparam int DCS_CTRL_STG = 2;
   localparam int DCS_CTRL_INIT = 3;
   // Mode register fields
   localparam int DCS_MODE_FLY = 0;
   localparam int DCS_MODE_HALF = 1;
   localparam int DCS_MODE_XFM = 2;
   localparam int DCS_MODE_SW = 4;
   localparam int DCS_MODE_SBE = 5;
   localparam int DCS_MODE_DW = 6;
   localparam int DCS_MODE_SK = 8;
   localparam int DCS_MODE_DK = 11;
   localparam int DCS_MODE_SW16 = 14; // Source bus is 16 bits wide
   // Trigger factor register: bit 7 selects peripheral interrupt, low bits its index
   localparam int DCS_TRIG_PER = 7;
   localparam logic [31:0] DCS_ALIAS_LO = 32'h03ff_f000;
   localparam logic [31:0] DCS_ALIAS_HI = 32'h03ff_ffff;
   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      DCS_T_PERIPH = 3'h0, DCS_T_EXTIO = 3'h1, DCS_T_IRAM = 3'h2,
      DCS_T_EXTMEM = 3'h3, DCS_T_SDRAM = 3'h4, DCS_T_IROM = 3'h5
   } dcs_target_t;
   typedef enum logic [1:0] {
      DCS_XM_SINGLE = 2'h0, DCS_XM_STEP = 2'h1, DCS_XM_BLOCK = 2'h2
   } dcs_xfer_mode_t;
   typedef enum logic [2:0] {
      DCS_CYC_NONE = 3'h0, DCS_CYC_SRAM = 3'h1, DCS_CYC_BCT = 3'h2, DCS_CYC_FLY = 3'h3
   } dcs_cycle_t;
   typedef enum logic [5:0] {
      DCS_IDLE = 6'b000001, DCS_START = 6'b000010, DCS_RD = 6'b000100,
      DCS_GAP = 6'b001000, DCS_WR = 6'b010000, DCS_END = 6'b100000
   } dcs_state_t;
endpackage

// [tb/dcs_sequencer_checker.sv]
// Port assertions for the DMA channel sequencer
`timescale 1ns/1ps
module dcs_sequencer_checker
   import dcs_pkg::*;
#(
   parameter int NCH = 4
) (
   // Clock, reset and APB answer
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   // External bus and channel status
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [1:0] bus_lane_en,
   input wire logic [15:0] bus_data_oe_n,
   input wire logic [NCH-1:0] transfer_acknowledge,
   input wire logic [NCH-1:0] terminal_count_pulse
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Ownership: one channel at a time, hand-over only through idle
   property p_ack_onehot; $onehot0(transfer_acknowledge); endproperty
   a_ack_onehot: assert property (p_ack_onehot)
      else $error("two channels own the sequencer");
   property p_ack_keep; (transfer_acknowledge != '0 && $past(transfer_acknowledge) != '0)
      |-> transfer_acknowledge == $past(transfer_acknowledge); endproperty
   a_ack_keep: assert property (p_ack_keep)
      else $error("owner switched without idle");
   // Data lane drive per beat kind
   property p_rd_release; (bus_rd && !bus_wr) |-> bus_data_oe_n == 16'hffff; endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("data driven during read");
   property p_byte_upper; (bus_wr && bus_lane_en == 2'b01) |-> &bus_data_oe_n[15:8]; endproperty
   a_byte_upper: assert property (p_byte_upper)
      else $error("upper lanes driven on byte write");
   property p_half_drive; (bus_wr && !bus_rd && bus_lane_en == 2'b11)
      |-> bus_data_oe_n == 16'h0000; endproperty
   a_half_drive: assert property (p_half_drive)
      else $error("halfword write not fully driven");
   // Terminal count is a single pulse from the owning channel
   property p_tc_pulse; terminal_count_pulse != '0 |=> terminal_count_pulse == '0; endproperty
   a_tc_pulse: assert property (p_tc_pulse)
      else $error("terminal count longer than one cycle");
   property p_tc_owner; terminal_count_pulse != '0 |-> (terminal_count_pulse &
      (transfer_acknowledge | $past(transfer_acknowledge))) == terminal_count_pulse; endproperty
   a_tc_owner: assert property (p_tc_owner)
      else $error("terminal count from a channel not owning");
   property p_beat_owned; (bus_rd || bus_wr) |-> transfer_acknowledge != '0; endproperty
   a_beat_owned: assert property (p_beat_owned)
      else $error("bus beat without acknowledge");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   // Main scenarios reached
   c_ack: cover property ($rose(|transfer_acknowledge));
   c_tc: cover property (|terminal_count_pulse);
   c_byte: cover property (bus_wr && bus_lane_en == 2'b01);
endmodule // dcs_sequencer_checker

// [tb/dcs_bus_model.sv]
// External memory model answering the sequencer's bus beats
`timescale 1ns/1ps
module dcs_bus_model (
   // Clock, reset and pace
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   // Beats from the sequencer
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [31:0] bus_addr,
   input wire logic [15:0] bus_wdata_out,
   // Answer
   output logic bus_ready,
   output logic [15:0] bus_rdata_in
);
   logic [47:0] wlog[$];
   logic [31:0] rlog[$];
   int wait_q = 0;
   int cool_q = 0;
   // Wait states per beat; the cool-down covers the strobes' one-cycle lag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_ready <= 1'b0;
         bus_rdata_in <= 16'hffff;
         cool_q = 0;
         wait_q = 0;
      end else begin
         bus_ready <= 1'b0;
         // Released lines toggle so a stale value never looks valid
         bus_rdata_in <= (bus_rd && !bus_wr) ? (bus_addr[15:0] ^ 16'h5a3c) : ~bus_rdata_in;
         if (cool_q > 0) begin
            cool_q = cool_q - 1;
         end else if (bus_rd || bus_wr) begin
            if (wait_q == 0) begin
               wait_q = slow ? 20 : 1 + $urandom_range(2);
            end
            wait_q = wait_q - 1;
            if (wait_q == 0) begin
               bus_ready <= 1'b1;
               cool_q = 3;
               if (bus_wr) wlog.push_back({bus_addr, bus_wdata_out});
               if (bus_rd) rlog.push_back(bus_addr);
            end
         end
      end
   end
endmodule // dcs_bus_model

// [tb/dcs_sequencer_bench.sv]
// Self-checking bench for the DMA channel sequencer
`timescale 1ns/1ps
module dcs_sequencer_bench
   import dcs_pkg::*;
;
   // ------------------------------
   // Wiring and bookkeeping
   // ------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, q, s, d, prdata, bus_addr;
   logic [3:0] ext_transfer_request = '0, transfer_acknowledge, terminal_count_pulse;
   logic [7:0] periph_irq = '0;
   logic pready, pslverr, bus_ready, bus_rd, bus_wr, e;
   logic [15:0] bus_rdata_in, bus_wdata_out, bus_data_oe_n, f, g;
   logic [1:0] bus_lane_en;
   logic [2:0] bus_cycle;
   int fail_count = 0, cmp_count = 0;
   // Clock at 250 MHz
   always #2 pclk = ~pclk;
   dcs_sequencer dcs_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_transfer_request(ext_transfer_request),
      .periph_irq(periph_irq), .bus_ready(bus_ready), .bus_rdata_in(bus_rdata_in),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_lane_en(bus_lane_en),
      .bus_cycle(bus_cycle), .bus_wdata_out(bus_wdata_out), .bus_data_oe_n(bus_data_oe_n),
      .transfer_acknowledge(transfer_acknowledge), .terminal_count_pulse(terminal_count_pulse));
   dcs_bus_model dcs_bus_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata_out(bus_wdata_out),
      .bus_ready(bus_ready), .bus_rdata_in(bus_rdata_in));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic give_verdict();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] v);
      cmp_count++;
      if (v !== x) begin
         $display("mismatch %s expected %h seen %h", nm, x, v);
         fail_count++;
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] v);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         give_verdict();
      end
   endtask
   function automatic logic [11:0] ra(input int ch, input logic [4:0] off);
      return 12'(DCS_CH_STRIDE * ch) + 12'(off);
   endfunction
   // Bounded wait for acknowledge (tc=0) or terminal count (tc=1)
   task automatic await(input bit tc, input int ch);
      int n;
      for (n = 0; n < 4000; n++) begin
         @(posedge pclk);
         if ((tc ? terminal_count_pulse[ch] : transfer_acknowledge[ch]) === 1'b1) break;
      end
      if (n == 4000) begin
         fail_count++;
         give_verdict();
      end
   endtask
   // Program a channel; a stale source is written first and must be overwritten
   task automatic setup(input int ch, input logic [31:0] mode, input logic [31:0] trig);
      s = 32'h0001_0000 | ($urandom & 32'h0000_7ff0);
      d = s | 32'h0000_8000;
      apb(1, ra(ch, DCS_OFF_SRC), ~s);
      apb(1, ra(ch, DCS_OFF_SRC), s);
      apb(1, ra(ch, DCS_OFF_DST), d);
      apb(1, ra(ch, DCS_OFF_CNT), 32'h1);
      apb(1, ra(ch, DCS_OFF_TRIG), trig);
      apb(1, ra(ch, DCS_OFF_MODE), mode);
      apb(0, ra(ch, DCS_OFF_SRC), '0);
      chk("src idle", s, q);
      apb(1, ra(ch, DCS_OFF_CTRL), 32'h1 << DCS_CTRL_EN);
      dcs_bus_model_i.rlog.delete();
      dcs_bus_model_i.wlog.delete();
      f = s[15:0] ^ 16'h5a3c;
      g = (s[15:0] + 16'h1) ^ 16'h5a3c;
   endtask
   task automatic chkw(input int i, input logic [31:0] a, input logic [15:0] v, input bit bt);
      logic [47:0] w;
      w = dcs_bus_model_i.wlog[i];
      chk("wr addr", a, w[47:16]);
      chk("wr data", {16'h0, bt ? 8'h0 : v[15:8], v[7:0]}, {16'h0, bt ? 8'h0 : w[15:8], w[7:0]});
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      void'($urandom(50));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ra(0, DCS_OFF_CTRL), '0);
      chk("ctrl reset", 32'h0, q);
      apb(0, 12'h0fc, '0);
      chk("unmapped err", 32'h1, {31'h0, e});
      // Software start, halfword source to byte destination
      setup(1, 32'h0000_5b1a, 32'h0);
      apb(1, ra(1, DCS_OFF_CTRL), 32'h5);
      await(1, 1);
      apb(0, ra(1, DCS_OFF_CTRL), '0);
      chk("first rd", s, dcs_bus_model_i.rlog[0]);
      chkw(0, d, {8'h0, f[7:0]}, 1);
      chkw(1, d + 1, {8'h0, f[15:8]}, 1);
      // External pin start, byte source to halfword destination
      setup(2, 32'h0000_1b4a, 32'h0);
      ext_transfer_request[2] <= 1'b1;
      await(0, 2);
      ext_transfer_request[2] <= 1'b0;
      await(1, 2);
      apb(0, ra(2, DCS_OFF_CTRL), '0);
      chk("rd hi", s + 1, dcs_bus_model_i.rlog[1]);
      chkw(0, d, {g[7:0], f[7:0]}, 0);
      // Peripheral start, byte onto halfword bus
      setup(3, 32'h0000_1b48, 32'h0000_0085);
      periph_irq[5] <= 1'b1;
      await(0, 3);
      periph_irq[5] <= 1'b0;
      await(1, 3);
      apb(0, ra(3, DCS_OFF_CTRL), '0);
      chkw(0, d, f, 1);
      // Two pins at once: channel 0 first, then channel 1 after it
      setup(1, 32'h0000_1b08, 32'h0);
      setup(0, 32'h0000_1b08, 32'h0);
      ext_transfer_request <= 4'b0011;
      await(0, 0);
      chk("ch1 not first", 32'h0, dcs_bus_model_i.wlog.size());
      ext_transfer_request[0] <= 1'b0;
      await(0, 1);
      ext_transfer_request[1] <= 1'b0;
      await(1, 1);
      apb(0, ra(0, DCS_OFF_CTRL), '0);
      apb(0, ra(1, DCS_OFF_CTRL), '0);
      chkw(0, d, f, 1);
      // Flyby, external memory to external I/O, both byte wide
      setup(0, 32'h0000_0b19, 32'h0);
      apb(1, ra(0, DCS_OFF_CTRL), 32'h5);
      await(0, 0);
      chk("fly cycle", 32'(DCS_CYC_FLY), {29'h0, bus_cycle});
      await(1, 0);
      apb(0, ra(0, DCS_OFF_CTRL), '0);
      chk("fly addr", s, dcs_bus_model_i.wlog[0][47:16]);
      // Slow bus: write while busy, then reload at terminal count
      slow <= 1'b1;
      setup(1, 32'h0000_1b1a, 32'h0);
      apb(1, ra(1, DCS_OFF_CTRL), 32'h5);
      await(0, 1);
      apb(1, ra(1, DCS_OFF_SRC), ~s);
      apb(0, ra(1, DCS_OFF_SRC), '0);
      chk("src busy", s, q);
      await(1, 1);
      apb(0, ra(1, DCS_OFF_SRC), '0);
      chk("src reload", ~s, q);
      give_verdict();
   end
endmodule // dcs_sequencer_bench
bind dcs_sequencer dcs_sequencer_checker #(.NCH(NCH)) dcs_sequencer_checker_i (
   .pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr), .bus_rd(bus_rd),
   .bus_wr(bus_wr), .bus_lane_en(bus_lane_en), .bus_data_oe_n(bus_data_oe_n),
   .transfer_acknowledge(transfer_acknowledge), .terminal_count_pulse(terminal_count_pulse));
